// ===== common/uiq_map.svh
// register map, field positions, reset values and timing counts for the
// interrupt identification and queue control block.
// assumes a byte-wide host register port with a 3-bit offset.
`ifndef UIQ_MAP_SVH
`define UIQ_MAP_SVH

`define UIQ_OFS_RX_BUFFER     3'h0
`define UIQ_OFS_TX_HOLDING    3'h0
`define UIQ_OFS_SOURCE_ID     3'h2
`define UIQ_OFS_QUEUE_CTRL    3'h2
`define UIQ_OFS_LINE_STATUS   3'h5
`define UIQ_OFS_MODEM_STATUS  3'h6

`define UIQ_QC_ENABLE         0
`define UIQ_QC_RX_RESET       1
`define UIQ_QC_TX_RESET       2
`define UIQ_QC_DMA_MODE       3
`define UIQ_QC_TRIG_LO        6
`define UIQ_QC_TRIG_HI        7
`define UIQ_QC_RESET          8'h00

`define UIQ_IER_RX_DATA       0

`define UIQ_ID_NONE           8'h01
`define UIQ_ID_FIFO_BITS      8'hC0

`define UIQ_TIMEOUT_CHARS     4

`define UIQ_TRIG_LEVEL_0      5'h01
`define UIQ_TRIG_LEVEL_1      5'h04
`define UIQ_TRIG_LEVEL_2      5'h08
`define UIQ_TRIG_LEVEL_3      5'h0E

`endif

// ===== common/uiq_pkg.sv
// types shared by the interrupt identification block.
// no assumptions beyond the map header.
package uiq_pkg;

	typedef enum logic [2:0] {
		UIQ_SRC_NONE    = 3'b000,
		UIQ_SRC_LINE    = 3'b001,
		UIQ_SRC_RXDATA  = 3'b010,
		UIQ_SRC_TIMEOUT = 3'b011,
		UIQ_SRC_TXEMPTY = 3'b100,
		UIQ_SRC_MODEM   = 3'b101
	} uiq_src_type;

endpackage : uiq_pkg

// ===== rtl/uiq_char_timeout.sv
// character time-out detector: counts character-time ticks while the
// receive queue holds data and sees no activity.
// assumes char_tick_i is a one-cycle enable pulse, one per character time.
`timescale 1ns/10ps
`include "uiq_map.svh"

module uiq_char_timeout #(
	parameter int CHARS = `UIQ_TIMEOUT_CHARS
) (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic arm_i,
	input  wire logic activity_i,
	input  wire logic char_tick_i,
	output logic      expired_o
);

	initial begin
		if (CHARS < 1 || CHARS > 15) begin
			$error("uiq_char_timeout: CHARS out of range");
		end
	end

	logic [3:0] count_r;
	logic [3:0] count_nxt;
	logic       expired_r;
	logic       expired_nxt;

	// ------------------------------------------------------------
	// idle character counter
	// ------------------------------------------------------------
	always_comb begin
		count_nxt   = count_r;
		expired_nxt = expired_r;
		if (!arm_i || activity_i) begin
			count_nxt   = 4'h0;
			expired_nxt = 1'b0;
		end else if (char_tick_i && !expired_r) begin
			count_nxt = count_r + 4'h1;
			if (count_r == 4'(CHARS - 1)) begin
				expired_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_r   <= 4'h0;
			expired_r <= 1'b0;
		end else begin
			count_r   <= count_nxt;
			expired_r <= expired_nxt;
		end
	end

	assign expired_o = expired_r;

	chk_timeout_needs_arm : assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		expired_r |-> $past(arm_i))
		else $error("time-out flagged without data held");

endmodule : uiq_char_timeout

// ===== rtl/uiq_int_ident.sv
// interrupt identification and queue control for one serial channel.
// assumes host reads and writes are one-cycle strobes with a 3-bit offset,
// and that the line, receive, transmit and modem logic supply their events.
//
// Contract
// - rank line status, received data, transmit empty, modem status; line clears by status read.
// - during an identification read, freeze the reported source until the access ends.
// - identification bit 0 reads 0 when something is pending, else 1.
// - bits 2:1 give 11 line, 10 data, 01 transmit, 00 modem; modem cleared by read.
// - data interrupt clears on buffer read or fill dropping below trigger in queue mode.
// - in queue mode, time-out after 4 idle character times with data held.
// - bit 3 is 0 outside queue mode, set with bit 2 only for time-out.
// - transmit empty clears on identification read naming it, or holding write.
// - bits 7:6 read 1 when queue enable is set, else 0.
// - bits 5:4 always read 0.
// - offset 2 reads identification and writes queue control.
// - queue control bits 7:6 pick the receive trigger fill level.
// - queue control bit 3 is storable but has no effect; no ready outputs.
// - writing bit 2 empties the transmit queue; the bit self-clears.
// - writing bit 1 empties the receive queue, not the shifter; self-clears.
// - setting bit 0 enables both queues.
// - clearing bit 0 disables both queues and discards contents.
// - leaving queue mode clears every queue control field except the two flush bits, which pulse.
// - trigger codes map to 1, 4, 8 and 14 bytes.
// - enable bit 0 gates the data and time-out interrupts.
`timescale 1ns/10ps
`include "uiq_map.svh"

module uiq_int_ident #(
	parameter int DEPTH = 16,
	parameter int CNT_W = 5
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	input  wire logic       rd_i,
	input  wire logic       wr_i,
	input  wire logic [2:0] addr_i,
	input  wire logic       dlab_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [3:0] int_enable_i,
	input  wire logic       line_event_i,
	input  wire logic       rx_char_i,
	input  wire logic       rx_pop_i,
	input  wire logic [CNT_W-1:0] rx_count_i,
	input  wire logic       tx_holding_empty_i,
	input  wire logic       modem_event_i,
	input  wire logic       char_tick_i,
	output logic [7:0]      rdata_o,
	output logic            rdata_valid_o,
	output logic            irq_o,
	output logic            queue_enable_o,
	output logic [1:0]      trigger_sel_o,
	output logic            tx_queue_flush_o,
	output logic            rx_queue_flush_o
);

	initial begin
		if (DEPTH < 14 || (1 << CNT_W) <= DEPTH) begin
			$error("uiq_int_ident: DEPTH or CNT_W cannot hold trigger levels");
		end
	end

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	logic id_rd;
	logic ctrl_wr;
	logic rxbuf_rd;
	logic txhold_wr;
	logic line_rd;
	logic modem_rd;

	assign id_rd     = rd_i && addr_i == `UIQ_OFS_SOURCE_ID;
	assign ctrl_wr   = wr_i && addr_i == `UIQ_OFS_QUEUE_CTRL;
	assign rxbuf_rd  = rd_i && !dlab_i && addr_i == `UIQ_OFS_RX_BUFFER;
	assign txhold_wr = wr_i && !dlab_i && addr_i == `UIQ_OFS_TX_HOLDING;
	assign line_rd   = rd_i && addr_i == `UIQ_OFS_LINE_STATUS;
	assign modem_rd  = rd_i && addr_i == `UIQ_OFS_MODEM_STATUS;

	// ------------------------------------------------------------
	// queue control register
	// ------------------------------------------------------------
	logic       qc_enable_r;
	logic       qc_enable_nxt;
	logic [1:0] qc_trig_r;
	logic [1:0] qc_trig_nxt;
	logic       qc_dma_r;
	logic       qc_dma_nxt;
	logic       tx_flush_r;
	logic       tx_flush_nxt;
	logic       rx_flush_r;
	logic       rx_flush_nxt;

	always_comb begin
		qc_enable_nxt = qc_enable_r;
		qc_trig_nxt   = qc_trig_r;
		qc_dma_nxt    = qc_dma_r;
		tx_flush_nxt  = 1'b0;   // self-clearing
		rx_flush_nxt  = 1'b0;   // self-clearing
		if (ctrl_wr) begin
			qc_enable_nxt = wdata_i[`UIQ_QC_ENABLE];
			if (wdata_i[`UIQ_QC_ENABLE]) begin
				// other fields land only with enable set
				qc_trig_nxt  = wdata_i[`UIQ_QC_TRIG_HI:`UIQ_QC_TRIG_LO];
				qc_dma_nxt   = wdata_i[`UIQ_QC_DMA_MODE];   // stored, unused
				tx_flush_nxt = wdata_i[`UIQ_QC_TX_RESET];
				rx_flush_nxt = wdata_i[`UIQ_QC_RX_RESET];
			end else begin
				qc_trig_nxt = 2'h0;
				qc_dma_nxt  = 1'b0;
				if (qc_enable_r) begin
					tx_flush_nxt = 1'b1;   // discard on disable
					rx_flush_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			qc_enable_r <= 1'b0;
			qc_trig_r   <= 2'h0;
			qc_dma_r    <= 1'b0;
			tx_flush_r  <= 1'b0;
			rx_flush_r  <= 1'b0;
		end else begin
			qc_enable_r <= qc_enable_nxt;
			qc_trig_r   <= qc_trig_nxt;
			qc_dma_r    <= qc_dma_nxt;
			tx_flush_r  <= tx_flush_nxt;
			rx_flush_r  <= rx_flush_nxt;
		end
	end

	assign queue_enable_o   = qc_enable_r;
	assign trigger_sel_o    = qc_trig_r;
	assign tx_queue_flush_o = tx_flush_r;
	assign rx_queue_flush_o = rx_flush_r;

	// ------------------------------------------------------------
	// receive trigger and time-out
	// ------------------------------------------------------------
	logic [CNT_W-1:0] trig_level;
	logic             rx_data_cond;
	logic             timeout_hit;

	always_comb begin
		case (qc_trig_r)
			2'h0:    trig_level = CNT_W'(`UIQ_TRIG_LEVEL_0);
			2'h1:    trig_level = CNT_W'(`UIQ_TRIG_LEVEL_1);
			2'h2:    trig_level = CNT_W'(`UIQ_TRIG_LEVEL_2);
			default: trig_level = CNT_W'(`UIQ_TRIG_LEVEL_3);
		endcase
	end

	// level-driven in queue mode so the source drops below trigger
	assign rx_data_cond = qc_enable_r && rx_count_i >= trig_level;

	uiq_char_timeout #(
		.CHARS(`UIQ_TIMEOUT_CHARS)
	) u_timeout (
		.clk_sys_i  (clk_sys_i),
		.rst_n_i    (rst_n_i),
		.arm_i      (qc_enable_r && rx_count_i != '0),
		.activity_i (rx_char_i || rx_pop_i || rxbuf_rd),
		.char_tick_i(char_tick_i),
		.expired_o  (timeout_hit)
	);

	// ------------------------------------------------------------
	// pending sources; set wins over clear
	// ------------------------------------------------------------
	logic line_pend_r;
	logic line_pend_nxt;
	logic rx_pend_r;
	logic rx_pend_nxt;
	logic tx_pend_r;
	logic tx_pend_nxt;
	logic tx_empty_q_r;
	logic modem_pend_r;
	logic modem_pend_nxt;
	logic hold_r;
	logic hold_nxt;
	uiq_pkg::uiq_src_type held_src_r;
	uiq_pkg::uiq_src_type held_src_nxt;
	uiq_pkg::uiq_src_type live_src;
	uiq_pkg::uiq_src_type shown_src;

	always_comb begin
		line_pend_nxt = line_event_i || (line_pend_r && !line_rd);
		modem_pend_nxt = modem_event_i || (modem_pend_r && !modem_rd);
		// non-queue mode: one received character raises it
		rx_pend_nxt = (!qc_enable_r && rx_char_i) || (!qc_enable_r && rx_pend_r && !rxbuf_rd);
		// rising edge of holding-empty arms it
		tx_pend_nxt = (tx_holding_empty_i && !tx_empty_q_r)
			|| (tx_pend_r && !txhold_wr
				&& !(id_rd && shown_src == uiq_pkg::UIQ_SRC_TXEMPTY));
	end

	always_comb begin
		// enable bit 0 gates data and time-out
		if (line_pend_r && int_enable_i[2]) begin
			live_src = uiq_pkg::UIQ_SRC_LINE;
		end else if (int_enable_i[`UIQ_IER_RX_DATA] && (rx_data_cond || rx_pend_r)) begin
			live_src = uiq_pkg::UIQ_SRC_RXDATA;
		end else if (int_enable_i[`UIQ_IER_RX_DATA] && qc_enable_r && timeout_hit) begin
			live_src = uiq_pkg::UIQ_SRC_TIMEOUT;
		end else if (tx_pend_r && int_enable_i[1]) begin
			live_src = uiq_pkg::UIQ_SRC_TXEMPTY;
		end else if (modem_pend_r && int_enable_i[3]) begin
			live_src = uiq_pkg::UIQ_SRC_MODEM;
		end else begin
			live_src = uiq_pkg::UIQ_SRC_NONE;
		end
	end

	// frozen for the cycle after an identification read
	assign shown_src = hold_r ? held_src_r : live_src;
	assign hold_nxt  = id_rd;
	assign held_src_nxt = id_rd ? shown_src : held_src_r;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			line_pend_r  <= 1'b0;
			rx_pend_r    <= 1'b0;
			tx_pend_r    <= 1'b0;
			tx_empty_q_r <= 1'b0;
			modem_pend_r <= 1'b0;
			hold_r       <= 1'b0;
			held_src_r   <= uiq_pkg::UIQ_SRC_NONE;
		end else begin
			line_pend_r  <= line_pend_nxt;
			rx_pend_r    <= rx_pend_nxt;
			tx_pend_r    <= tx_pend_nxt;
			tx_empty_q_r <= tx_holding_empty_i;
			modem_pend_r <= modem_pend_nxt;
			hold_r       <= hold_nxt;
			held_src_r   <= held_src_nxt;
		end
	end

	// ------------------------------------------------------------
	// identification byte and read data
	// ------------------------------------------------------------
	logic [7:0] id_byte;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       rvalid_r;
	logic       irq_r;

	always_comb begin
		case (shown_src)
			uiq_pkg::UIQ_SRC_LINE:    id_byte = 8'h06;
			uiq_pkg::UIQ_SRC_RXDATA:  id_byte = 8'h04;
			uiq_pkg::UIQ_SRC_TIMEOUT: id_byte = 8'h0C;
			uiq_pkg::UIQ_SRC_TXEMPTY: id_byte = 8'h02;
			uiq_pkg::UIQ_SRC_MODEM:   id_byte = 8'h00;
			default:                  id_byte = `UIQ_ID_NONE;
		endcase
		// bits 5:4 stay zero
		if (qc_enable_r) begin
			id_byte = id_byte | `UIQ_ID_FIFO_BITS;
		end
		rdata_nxt = id_rd ? id_byte : 8'h00;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
			irq_r    <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= id_rd;
			irq_r    <= shown_src != uiq_pkg::UIQ_SRC_NONE;
		end
	end

	assign rdata_o       = rdata_r;
	assign rdata_valid_o = rvalid_r;
	assign irq_o         = irq_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_id_read;
		id_rd;
	endsequence

	chk_id_bit0 : assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_id_read |=> rdata_o[0] == ($past(shown_src) == uiq_pkg::UIQ_SRC_NONE))
		else $error("identification bit 0 wrong");
	chk_id_reserved : assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		rdata_o[5:4] == 2'b00)
		else $error("reserved identification bits set");
	chk_id_fifo_bits : assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_id_read |=> rdata_o[7:6] == {2{$past(qc_enable_r)}})
		else $error("identification bits 7:6 wrong");
	chk_bit3_mode : assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		rdata_o[3] |-> rdata_o[2] && rdata_o[7])
		else $error("bit 3 without time-out");
	chk_line_first : assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		line_pend_r && int_enable_i[2] && !hold_r |-> shown_src == uiq_pkg::UIQ_SRC_LINE)
		else $error("line status not top priority");
	chk_hold_read : assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_id_read |=> shown_src == $past(shown_src))
		else $error("source changed during identification read");
	chk_flush_pulse : assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		tx_queue_flush_o |=> !tx_queue_flush_o || $past(ctrl_wr))
		else $error("transmit flush did not self-clear");
	chk_mode_off_clear : assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		ctrl_wr && !wdata_i[0] |=> qc_trig_r == 2'h0 && !qc_dma_r && !qc_enable_r)
		else $error("control fields kept after leaving queue mode");

endmodule : uiq_int_ident

// ===== dv/uiq_host_model.sv
// host processor model: single-byte register reads and writes on the channel port.
// assumes one-cycle strobes and an answer registered one cycle after the read.
`timescale 1ns/10ps

module uiq_host_model (
	input  wire logic       clk_sys_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rdata_valid_i,
	output logic            rd_o,
	output logic            wr_o,
	output logic [2:0]      addr_o,
	output logic [7:0]      wdata_o
);
	initial begin
		rd_o    <= 1'b0;
		wr_o    <= 1'b0;
		addr_o  <= 3'h0;
		wdata_o <= 8'h00;
	end

	// the caller sets bit 0 in queue control writes that set other bits, except the 8'hC6 write in sc_off
	task automatic wr_reg(input logic [2:0] ofs, input logic [7:0] dat);
		@(posedge clk_sys_i);
		wr_o    <= 1'b1;
		addr_o  <= ofs;
		wdata_o <= dat;
		@(posedge clk_sys_i);
		wr_o    <= 1'b0;
		// released data never repeats the last value
		wdata_o <= ~dat;
		@(negedge clk_sys_i);
	endtask : wr_reg

	task automatic rd_reg(input logic [2:0] ofs, output logic [7:0] dat, output logic vld);
		@(posedge clk_sys_i);
		rd_o   <= 1'b1;
		addr_o <= ofs;
		@(posedge clk_sys_i);
		rd_o   <= 1'b0;
		// the answer launched at the taking edge is sampled at the next edge
		@(posedge clk_sys_i);
		dat = rdata_i;
		vld = rdata_valid_i;
	endtask : rd_reg
endmodule : uiq_host_model

// ===== dv/test_uiq_int_ident.sv
// self-checking bench for the interrupt identification and queue control block.
// assumes the host model above drives the register port.
`timescale 1ns/10ps

module test_uiq_int_ident;
	logic       clk_sys_i;
	logic       rst_n_i;
	logic       rd_i;
	logic       wr_i;
	logic [2:0] addr_i;
	logic       dlab_i;
	logic [7:0] wdata_i;
	logic [3:0] int_enable_i;
	logic       line_event_i;
	logic       rx_char_i;
	logic       rx_pop_i;
	logic [4:0] rx_count_i;
	logic       tx_holding_empty_i;
	logic       modem_event_i;
	logic       char_tick_i;
	logic [7:0] rdata_o;
	logic       rdata_valid_o;
	logic       irq_o;
	logic       queue_enable_o;
	logic [1:0] trigger_sel_o;
	logic       tx_queue_flush_o;
	logic       rx_queue_flush_o;
	int         miscompares;
	int         tests_run;
	int         cycles;

	uiq_int_ident dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rd_i(rd_i), .wr_i(wr_i),
		.addr_i(addr_i), .dlab_i(dlab_i), .wdata_i(wdata_i), .int_enable_i(int_enable_i),
		.line_event_i(line_event_i), .rx_char_i(rx_char_i), .rx_pop_i(rx_pop_i),
		.rx_count_i(rx_count_i), .tx_holding_empty_i(tx_holding_empty_i),
		.modem_event_i(modem_event_i), .char_tick_i(char_tick_i), .rdata_o(rdata_o),
		.rdata_valid_o(rdata_valid_o), .irq_o(irq_o), .queue_enable_o(queue_enable_o),
		.trigger_sel_o(trigger_sel_o), .tx_queue_flush_o(tx_queue_flush_o),
		.rx_queue_flush_o(rx_queue_flush_o));

	uiq_host_model host (.clk_sys_i(clk_sys_i), .rdata_i(rdata_o),
		.rdata_valid_i(rdata_valid_o), .rd_o(rd_i), .wr_o(wr_i), .addr_o(addr_i),
		.wdata_o(wdata_i));

	initial clk_sys_i = 1'b0;
	always #25 clk_sys_i = ~clk_sys_i;

	// ---------------------------------------------------------------
	// checking helpers
	// ---------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask : chk

	task automatic rid(input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		host.rd_reg(3'h2, d, v);
		chk("id byte", {1'b1, exp}, {v, d});
	endtask : rid

	// reads another offset, which clears its source and shows nothing here
	task automatic rclr(input logic [2:0] ofs);
		logic [7:0] d;
		logic       v;
		host.rd_reg(ofs, d, v);
		chk("other read", 9'h000, {v, d});
	endtask : rclr

	task automatic wq(input logic [7:0] dat, input logic [4:0] exp);
		host.wr_reg(3'h2, dat);
		chk("queue ctrl", {4'h0, exp},
			{4'h0, queue_enable_o, trigger_sel_o, tx_queue_flush_o, rx_queue_flush_o});
	endtask : wq

	task automatic ev(input logic [4:0] m);
		@(posedge clk_sys_i);
		{line_event_i, rx_char_i, rx_pop_i, modem_event_i, char_tick_i} <= m;
		@(posedge clk_sys_i);
		{line_event_i, rx_char_i, rx_pop_i, modem_event_i, char_tick_i} <= 5'h00;
	endtask : ev

	task automatic chk_irq(input logic exp);
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk("irq", {8'h00, exp}, {8'h00, irq_o});
	endtask : chk_irq

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	// all four classes at once, then cleared one at a time in rank order
	task automatic sc_prio();
		@(posedge clk_sys_i);
		tx_holding_empty_i <= 1'b1;
		ev(5'h1A);
		chk_irq(1'b1);
		rid(8'h06);
		rclr(3'h5);
		rid(8'h04);
		rclr(3'h0);
		rid(8'h02);
		rid(8'h00);
		rclr(3'h6);
		rid(8'h01);
		chk_irq(1'b0);
	endtask : sc_prio

	task automatic sc_queue();
		wq(8'h8F, 5'b1_10_11);
		wq(8'hC1, 5'b1_11_00);
		rid(8'hC1);
		rx_count_i <= 5'd13;
		rid(8'hC1);
		rx_count_i <= 5'd14;
		rid(8'hC4);
		rx_count_i <= 5'd13;
		rid(8'hC1);
		int_enable_i <= 4'hE;
		repeat (4) ev(5'h01);
		rid(8'hC1);
		int_enable_i <= 4'hF;
		rid(8'hCC);
		rclr(3'h0);
		rid(8'hC1);
	endtask : sc_queue

	// the three lower trigger codes: code 0 at its level, codes 1 and 2 just below and at theirs
	task automatic sc_trig();
		rx_count_i <= 5'd0;
		wq(8'h01, 5'b1_00_00);
		@(posedge clk_sys_i);
		rx_count_i <= 5'd1;
		rid(8'hC4);
		wq(8'h41, 5'b1_01_00);
		@(posedge clk_sys_i);
		rx_count_i <= 5'd3;
		rid(8'hC1);
		rx_count_i <= 5'd4;
		rid(8'hC4);
		wq(8'h81, 5'b1_10_00);
		@(posedge clk_sys_i);
		rx_count_i <= 5'd7;
		rid(8'hC1);
		rx_count_i <= 5'd8;
		rid(8'hC4);
	endtask : sc_trig

	task automatic sc_off();
		rx_count_i <= 5'd0;
		wq(8'h00, 5'b0_00_11);
		rid(8'h01);
		wq(8'hC6, 5'b0_00_00);
		rid(8'h01);
	endtask : sc_off

	// transmit empty cleared by a holding register write
	task automatic sc_txw();
		tx_holding_empty_i <= 1'b0;
		@(posedge clk_sys_i);
		tx_holding_empty_i <= 1'b1;
		chk_irq(1'b1);
		host.wr_reg(3'h0, 8'h55);
		chk_irq(1'b0);
		rid(8'h01);
	endtask : sc_txw

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		miscompares = 0;
		tests_run = 0;
		cycles = 0;
		rst_n_i <= 1'b0;
		dlab_i <= 1'b0;
		int_enable_i <= 4'hF;
		{line_event_i, rx_char_i, rx_pop_i, modem_event_i, char_tick_i} <= 5'h00;
		rx_count_i <= 5'd0;
		tx_holding_empty_i <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rid(8'h01);
		sc_prio();
		sc_queue();
		sc_trig();
		sc_off();
		sc_txw();
		wrap_up();
	end
endmodule : test_uiq_int_ident
